// ===== include/cbs_pkg.sv
// Constants and carrier types for the core bank, status and system control registers
// ----------------------------------------------------------------------------
package cbs_pkg;

  // --------------------------------------------------------------------------
  // Special register addresses
  // --------------------------------------------------------------------------
  localparam logic [7:0] CBS_ADDR_PORT_A   = 8'h00;
  localparam logic [7:0] CBS_ADDR_PTR_A    = 8'h01;
  localparam logic [7:0] CBS_ADDR_PORT_B   = 8'h02;
  localparam logic [7:0] CBS_ADDR_PTR_B    = 8'h03;
  localparam logic [7:0] CBS_ADDR_BANK     = 8'h04;
  localparam logic [7:0] CBS_ADDR_PC_LOW   = 8'h06;
  localparam logic [7:0] CBS_ADDR_CTRL_A   = 8'h09;
  localparam logic [7:0] CBS_ADDR_FLAGS    = 8'h0A;
  localparam logic [7:0] CBS_ADDR_CTRL_B   = 8'h28;
  localparam logic [7:0] CBS_GPR_BASE      = 8'h40;

  // --------------------------------------------------------------------------
  // Field positions, masks and values after reset
  // --------------------------------------------------------------------------
  localparam int         CBS_BANK_PROG_BIT = 5;
  localparam logic [7:0] CBS_BANK_MASK     = 8'h23;
  localparam logic [7:0] CBS_BANK_RESET    = 8'h00;
  localparam int         CBS_FL_TIMEOUT    = 5;
  localparam int         CBS_FL_PWRDN      = 4;
  localparam int         CBS_FL_OVF        = 3;
  localparam int         CBS_FL_Z          = 2;
  localparam int         CBS_FL_AUX        = 1;
  localparam int         CBS_FL_C          = 0;
  localparam logic [7:0] CBS_FL_SW_MASK    = 8'h0F;
  localparam logic [7:0] CBS_FL_RESET      = 8'h00;
  localparam logic [7:0] CBS_CA_RESET      = 8'h01;
  localparam logic [7:0] CBS_CB_MASK       = 8'hC3;
  localparam logic [7:0] CBS_CB_RESET      = 8'h01;
  localparam logic [7:0] CBS_PTR_RESET     = 8'h00;
  localparam logic [3:0] CBS_LCD_DIV3      = 4'h3;
  localparam logic [3:0] CBS_LCD_DIV4      = 4'h4;
  localparam logic [3:0] CBS_LCD_DIV8      = 4'h8;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CBS_OP_NONE, CBS_OP_ADD, CBS_OP_SUB, CBS_OP_LOGIC, CBS_OP_RLC, CBS_OP_RRC
  } cbs_alu_op_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cbs_sfr_req_t;

  typedef struct packed {
    cbs_alu_op_t op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic        cin;
  } cbs_alu_req_t;

  typedef struct packed {
    logic wdt_timeout;
    logic clear_watchdog_instruction;
    logic halt;
    logic warm_reset;
    logic warm_reset_wdt_pd;
  } cbs_sys_evt_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cbs_ram_req_t;

  typedef struct packed {
    logic [1:0] timer2_src;
    logic       low_freq_src;
    logic [3:0] lcd_div;
    logic       sub_clock_keep;
    logic       sub_clock_src;
    logic       crystal_low_power;
    logic       irq_fall_en;
    logic       irq_rise_en;
    logic       buzzer_src;
    logic       crystal_keep;
  } cbs_clk_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       from_ram;
    logic [7:0] data;
  } cbs_rd_stage_t;

  typedef struct packed {
    logic [7:0]    ptr_a;
    logic [7:0]    ptr_b;
    logic [7:0]    bank;
    logic [7:0]    flags;
    logic [7:0]    ctrl_a;
    logic [7:0]    ctrl_b;
    cbs_ram_req_t  ram;
    cbs_rd_stage_t st1;
    cbs_rd_stage_t st2;
    logic [7:0]    rdata;
    logic          rvalid;
    logic          pc_load;
    logic [13:0]   pc_target;
    logic          dummy;
    cbs_clk_cfg_t  cfg;
  } cbs_state_t;

endpackage

// ===== verilog/cbs_regs.sv
// Core special registers: pointers, bank select, flags and system control
`timescale 1ns/1ps
module cbs_regs
  import cbs_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire cbs_sfr_req_t sfr_req_i,
  input  wire cbs_alu_req_t alu_i,
  input  wire cbs_sys_evt_t evt_i,
  input  wire logic         touch_enable_i,
  input  wire logic [13:0]  pc_i,
  input  wire logic [7:0]   ram_rdata_i,
  output logic [7:0]        rdata_o,
  output logic              rvalid_o,
  output cbs_ram_req_t      ram_req_o,
  output logic              pc_load_o,
  output logic [13:0]       pc_target_o,
  output logic              dummy_cycle_o,
  output logic              prog_bank_o,
  output logic [1:0]        data_bank_o,
  output logic [7:0]        flags_o,
  output cbs_clk_cfg_t      clk_cfg_o
);

  // --------------------------------------------------------------------------
  // Clock configuration decode
  // --------------------------------------------------------------------------
  function automatic cbs_clk_cfg_t cfg_of(input logic [7:0] ca, input logic [7:0] cb);
    cbs_clk_cfg_t c;
    c.timer2_src        = ca[7:6];
    c.low_freq_src      = ca[5];
    unique case (ca[4:3])
      2'b00:   c.lcd_div = CBS_LCD_DIV3;
      2'b01:   c.lcd_div = CBS_LCD_DIV4;
      default: c.lcd_div = CBS_LCD_DIV8;
    endcase
    c.sub_clock_keep    = ca[2];
    c.sub_clock_src     = ca[1];
    c.crystal_low_power = ca[0];
    c.irq_fall_en       = cb[6];
    c.irq_rise_en       = cb[7];
    c.buzzer_src        = cb[1];
    c.crystal_keep      = cb[0];
    return c;
  endfunction

  localparam cbs_state_t RESET_S = '{
    ptr_a:     CBS_PTR_RESET,
    ptr_b:     CBS_PTR_RESET,
    bank:      CBS_BANK_RESET,
    flags:     CBS_FL_RESET,
    ctrl_a:    CBS_CA_RESET,
    ctrl_b:    CBS_CB_RESET,
    ram:       '0,
    st1:       '0,
    st2:       '0,
    rdata:     8'h00,
    rvalid:    1'b0,
    pc_load:   1'b0,
    pc_target: 14'h0000,
    dummy:     1'b0,
    cfg:       cfg_of(CBS_CA_RESET, CBS_CB_RESET)
  };

  cbs_state_t s_r;
  cbs_state_t s_nxt;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic       via_a;
    logic       via_b;
    logic [7:0] eff;
    logic [1:0] bank;
    logic       to_ram;
    logic       self_ref;
    logic [7:0] sfr_rd;
    logic [7:0] bx;
    logic [8:0] sum;
    logic [4:0] lo_sum;
    logic [7:0] low7_sum;
    via_a    = 1'b0;
    via_b    = 1'b0;
    eff      = 8'h00;
    bank     = 2'b00;
    to_ram   = 1'b0;
    self_ref = 1'b0;
    sfr_rd   = 8'h00;
    bx       = 8'h00;
    sum      = 9'h000;
    lo_sum   = 5'h00;
    low7_sum = 8'h00;
    s_nxt    = s_r;

    s_nxt.ram.rd  = 1'b0;
    s_nxt.ram.wr  = 1'b0;
    s_nxt.pc_load = 1'b0;
    s_nxt.dummy   = 1'b0;

    // Address resolution; indirect ports redirect through their pointer
    via_a = (sfr_req_i.addr == CBS_ADDR_PORT_A);
    via_b = (sfr_req_i.addr == CBS_ADDR_PORT_B);
    if (via_a) begin
      eff = s_r.ptr_a;
    end else if (via_b) begin
      eff = s_r.ptr_b;
    end else begin
      eff = sfr_req_i.addr;
    end
    bank     = via_b ? s_r.bank[1:0] : 2'b00;
    // Special area ignores the bank so its registers stay reachable
    to_ram   = (eff >= CBS_GPR_BASE);
    // An indirect port reached indirectly is not a real register
    self_ref = (via_a || via_b) &&
               (eff == CBS_ADDR_PORT_A || eff == CBS_ADDR_PORT_B);

    // Special register read mux; unimplemented bits and addresses read zero
    unique case (eff)
      CBS_ADDR_PTR_A:  sfr_rd = s_r.ptr_a;
      CBS_ADDR_PTR_B:  sfr_rd = s_r.ptr_b;
      CBS_ADDR_BANK:   sfr_rd = s_r.bank & CBS_BANK_MASK;
      CBS_ADDR_PC_LOW: sfr_rd = pc_i[7:0];
      CBS_ADDR_CTRL_A: sfr_rd = s_r.ctrl_a;
      CBS_ADDR_FLAGS:  sfr_rd = s_r.flags;
      CBS_ADDR_CTRL_B: sfr_rd = s_r.ctrl_b & CBS_CB_MASK;
      default:         sfr_rd = 8'h00;
    endcase

    // Read pipeline: fixed three-cycle answer for both register and RAM reads,
    // so mixed back-to-back reads return in order
    s_nxt.st1.valid    = sfr_req_i.rd;
    s_nxt.st1.from_ram = to_ram;
    s_nxt.st1.data     = self_ref ? 8'h00 : sfr_rd;
    s_nxt.st2          = s_r.st1;
    s_nxt.rvalid       = s_r.st2.valid;
    if (s_r.st2.valid) begin
      s_nxt.rdata = s_r.st2.from_ram ? ram_rdata_i : s_r.st2.data;
    end

    if (to_ram) begin
      s_nxt.ram.rd    = sfr_req_i.rd;
      s_nxt.ram.wr    = sfr_req_i.wr;
      s_nxt.ram.bank  = bank;
      s_nxt.ram.addr  = eff;
      s_nxt.ram.wdata = sfr_req_i.wdata;
    end

    // ALU flag update
    bx       = (alu_i.op == CBS_OP_SUB) ? ~alu_i.b : alu_i.b;
    sum      = {1'b0, alu_i.a} + {1'b0, bx} + {8'h00, alu_i.cin};
    lo_sum   = {1'b0, alu_i.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, alu_i.cin};
    low7_sum = {1'b0, alu_i.a[6:0]} + {1'b0, bx[6:0]} + {7'h00, alu_i.cin};
    unique case (alu_i.op)
      CBS_OP_ADD, CBS_OP_SUB: begin
        // Subtract adds the complement, so carry means no borrow
        s_nxt.flags[CBS_FL_C]  = sum[8];
        s_nxt.flags[CBS_FL_AUX] = lo_sum[4];
        s_nxt.flags[CBS_FL_Z]  = (sum[7:0] == 8'h00);
        s_nxt.flags[CBS_FL_OVF] = low7_sum[7] ^ sum[8];
      end
      CBS_OP_LOGIC: begin
        s_nxt.flags[CBS_FL_Z]  = (alu_i.a == 8'h00);
      end
      CBS_OP_RLC: begin
        s_nxt.flags[CBS_FL_C]  = alu_i.a[7];
      end
      CBS_OP_RRC: begin
        s_nxt.flags[CBS_FL_C]  = alu_i.a[0];
      end
      default: begin
      end
    endcase

    // Register writes; a write in the same cycle overrides the ALU flags
    if (sfr_req_i.wr && !to_ram && !self_ref) begin
      unique case (eff)
        CBS_ADDR_PTR_A: s_nxt.ptr_a = sfr_req_i.wdata;
        CBS_ADDR_PTR_B: s_nxt.ptr_b = sfr_req_i.wdata;
        CBS_ADDR_BANK:  s_nxt.bank  = sfr_req_i.wdata & CBS_BANK_MASK;
        CBS_ADDR_PC_LOW: begin
          s_nxt.pc_load   = 1'b1;
          s_nxt.dummy     = 1'b1;
          s_nxt.pc_target = {pc_i[13:8], sfr_req_i.wdata};
        end
        CBS_ADDR_FLAGS: begin
          s_nxt.flags = (s_nxt.flags & ~CBS_FL_SW_MASK) |
                        (sfr_req_i.wdata & CBS_FL_SW_MASK);
        end
        CBS_ADDR_CTRL_A: s_nxt.ctrl_a = sfr_req_i.wdata;
        CBS_ADDR_CTRL_B: s_nxt.ctrl_b = sfr_req_i.wdata & CBS_CB_MASK;
        default: begin
        end
      endcase
    end
    if (!touch_enable_i) begin
      s_nxt.ctrl_a[7:6] = 2'b00;
    end

    // System flags; a setting event wins over a clearing one
    if (evt_i.clear_watchdog_instruction || evt_i.halt) begin
      s_nxt.flags[CBS_FL_TIMEOUT] = 1'b0;
    end
    if (evt_i.wdt_timeout) begin
      s_nxt.flags[CBS_FL_TIMEOUT] = 1'b1;
    end
    if (evt_i.clear_watchdog_instruction) begin
      s_nxt.flags[CBS_FL_PWRDN] = 1'b0;
    end
    if (evt_i.halt) begin
      s_nxt.flags[CBS_FL_PWRDN] = 1'b1;
    end

    // Non power-up reset: bank select cleared unless waking by watchdog
    if (evt_i.warm_reset) begin
      if (!evt_i.warm_reset_wdt_pd) begin
        s_nxt.bank = CBS_BANK_RESET;
      end
      s_nxt.ram     = '0;
      s_nxt.st1     = '0;
      s_nxt.st2     = '0;
      s_nxt.rvalid  = 1'b0;
      s_nxt.pc_load = 1'b0;
      s_nxt.dummy   = 1'b0;
    end

    s_nxt.cfg = cfg_of(s_nxt.ctrl_a, s_nxt.ctrl_b);
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= RESET_S;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all straight from the state register
  // --------------------------------------------------------------------------
  assign rdata_o       = s_r.rdata;
  assign rvalid_o      = s_r.rvalid;
  assign ram_req_o     = s_r.ram;
  assign pc_load_o     = s_r.pc_load;
  assign pc_target_o   = s_r.pc_target;
  assign dummy_cycle_o = s_r.dummy;
  assign prog_bank_o   = s_r.bank[CBS_BANK_PROG_BIT];
  assign data_bank_o   = s_r.bank[1:0];
  assign flags_o       = s_r.flags;
  assign clk_cfg_o     = s_r.cfg;

endmodule

// ===== sim/cbs_regs_assertions.sv
// Concurrent checks on the ports of the core special register block
`timescale 1ns/1ps
module cbs_regs_chk
  import cbs_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         reset_i,
  input wire cbs_sfr_req_t sfr_req_i,
  input wire cbs_alu_req_t alu_i,
  input wire cbs_sys_evt_t evt_i,
  input wire logic         touch_enable_i,
  input wire logic [13:0]  pc_i,
  input wire logic         rvalid_o,
  input wire cbs_ram_req_t ram_req_o,
  input wire logic         pc_load_o,
  input wire logic [13:0]  pc_target_o,
  input wire logic         dummy_cycle_o,
  input wire logic         prog_bank_o,
  input wire logic [1:0]   data_bank_o,
  input wire logic [7:0]   flags_o,
  input wire cbs_clk_cfg_t clk_cfg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Expected add flags, overflow down to carry, from this cycle's operands
  logic [8:0] sum;
  logic [4:0] lo;
  logic [3:0] af;
  always_comb begin
    sum = {1'b0, alu_i.a} + {1'b0, alu_i.b} + 9'(alu_i.cin);
    lo  = {1'b0, alu_i.a[3:0]} + {1'b0, alu_i.b[3:0]} + 5'(alu_i.cin);
    af  = {(alu_i.a[7] == alu_i.b[7]) && (sum[7] != alu_i.a[7]), sum[7:0] == 8'h00,
           lo[4], sum[8]};
  end
  property p_rd_lat; sfr_req_i.rd |-> ##3 rvalid_o; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer not in cycle 3");
  property p_pc_jump;
    sfr_req_i.wr && sfr_req_i.addr == CBS_ADDR_PC_LOW |=> pc_load_o && dummy_cycle_o
      && pc_target_o == {$past(pc_i[13:8]), $past(sfr_req_i.wdata)};
  endproperty
  a_pc_jump: assert property (p_pc_jump) else $error("low pc write did not jump");
  property p_timeout;
    1'b1 |=> flags_o[CBS_FL_TIMEOUT] == ($past(evt_i.wdt_timeout)
      || ($past(flags_o[CBS_FL_TIMEOUT]) && !$past(evt_i.clear_watchdog_instruction) && !$past(evt_i.halt)));
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out flag wrong");
  property p_pwrdn;
    1'b1 |=> flags_o[CBS_FL_PWRDN] == ($past(evt_i.halt)
      || ($past(flags_o[CBS_FL_PWRDN]) && !$past(evt_i.clear_watchdog_instruction)));
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("power-down flag wrong");
  property p_add;
    alu_i.op == CBS_OP_ADD && !sfr_req_i.wr |=> flags_o[3:0] == $past(af);
  endproperty
  a_add: assert property (p_add) else $error("add flags wrong");
  property p_direct;
    sfr_req_i.wr && sfr_req_i.addr >= CBS_GPR_BASE |=> ram_req_o.wr
      && ram_req_o.bank == 2'b00 && ram_req_o.addr == $past(sfr_req_i.addr);
  endproperty
  a_direct: assert property (p_direct) else $error("direct write left bank 0");
  property p_bank;
    sfr_req_i.wr && sfr_req_i.addr == CBS_ADDR_BANK && !evt_i.warm_reset
      |=> {prog_bank_o, data_bank_o} == {$past(sfr_req_i.wdata[5]), $past(sfr_req_i.wdata[1:0])};
  endproperty
  a_bank: assert property (p_bank) else $error("bank outputs wrong");
  property p_warm;
    evt_i.warm_reset
      |=> data_bank_o == ($past(evt_i.warm_reset_wdt_pd) ? $past(data_bank_o) : 2'b00);
  endproperty
  a_warm: assert property (p_warm) else $error("bank after warm reset wrong");
  property p_touch;
    !touch_enable_i ##1 !touch_enable_i ##1 !touch_enable_i |-> clk_cfg_o.timer2_src == 2'b00;
  endproperty
  a_touch: assert property (p_touch) else $error("timer 2 source not 00");
  c_pc_jump: cover property (pc_load_o);
  c_ram: cover property (ram_req_o.rd && ram_req_o.bank == 2'b11);
  c_keep: cover property (evt_i.warm_reset && evt_i.warm_reset_wdt_pd);
endmodule
bind cbs_regs cbs_regs_chk cbs_regs_chk_inst (.clk_i(clk_i), .reset_i(reset_i),
  .sfr_req_i(sfr_req_i), .alu_i(alu_i), .evt_i(evt_i), .touch_enable_i(touch_enable_i),
  .pc_i(pc_i), .rvalid_o(rvalid_o), .ram_req_o(ram_req_o), .pc_load_o(pc_load_o),
  .pc_target_o(pc_target_o), .dummy_cycle_o(dummy_cycle_o), .prog_bank_o(prog_bank_o),
  .data_bank_o(data_bank_o), .flags_o(flags_o), .clk_cfg_o(clk_cfg_o));

// ===== sim/cbs_regs_bench.sv
// Self-checking bench for the core special register block
`timescale 1ns/1ps
module cbs_regs_bench
  import cbs_pkg::*;
;
  logic         clk_i, reset_i, touch_enable_i, rvalid_o, pc_load_o, dummy_cycle_o, prog_bank_o;
  cbs_sfr_req_t sfr_req_i;
  cbs_alu_req_t alu_i;
  cbs_sys_evt_t evt_i;
  logic [13:0]  pc_i, pc_target_o;
  logic [7:0]   ram_rdata_i, rdata_o, flags_o, fl, v, ram [1024];
  logic [1:0]   data_bank_o;
  cbs_ram_req_t ram_req_o;
  cbs_clk_cfg_t clk_cfg_o;
  int           miscompares, checks, pa, pb, bk, mdl [int];
  logic [15:0]  rv [7] = '{16'h0100, 16'h0300, 16'h0400, 16'h0901, 16'h0A00, 16'h2801, 16'h0500};
  logic [4:0]   ev [5] = '{5'h04, 5'h10, 5'h14, 5'h08, 5'h10};
  cbs_regs cbs_regs_inst (.clk_i(clk_i), .reset_i(reset_i), .sfr_req_i(sfr_req_i),
    .alu_i(alu_i), .evt_i(evt_i), .touch_enable_i(touch_enable_i), .pc_i(pc_i),
    .ram_rdata_i(ram_rdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .ram_req_o(ram_req_o),
    .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .dummy_cycle_o(dummy_cycle_o),
    .prog_bank_o(prog_bank_o), .data_bank_o(data_bank_o), .flags_o(flags_o),
    .clk_cfg_o(clk_cfg_o));
  // Synchronous RAM; idle read data churns so a stale value never passes
  always @(posedge clk_i) begin
    ram_rdata_i <= ram_req_o.rd ? ram[{ram_req_o.bank, ram_req_o.addr}] : 8'($urandom);
    if (ram_req_o.wr)
      ram[{ram_req_o.bank, ram_req_o.addr}] <= ram_req_o.wdata;
  end
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) sfr_req_i <= '{1'b0, 1'b1, a, d};
    @(posedge clk_i) sfr_req_i <= '0;
  endtask
  // Answer is due exactly in the third cycle after the request
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i) sfr_req_i <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk_i) sfr_req_i <= '0;
    repeat (2) @(posedge clk_i);
    #1 chk({rvalid_o, rdata_o}, {1'b1, e});
  endtask
  task automatic evt(input logic [4:0] e);
    @(posedge clk_i) evt_i <= e;
    @(posedge clk_i) evt_i <= '0;
    #1;
  endtask
  // Model: where an access lands, as bank*256 + address
  function automatic int key(input logic [7:0] a);
    if (a == CBS_ADDR_PORT_A)
      return pa;
    if (a == CBS_ADDR_PORT_B)
      return (bk % 4) * 256 + pb;
    return a;
  endfunction
  task automatic wrm(input logic [7:0] a, input logic [7:0] d);
    int k;
    k = key(a);
    wr(a, d);
    if (k % 256 >= 64)
      mdl[k] = d;
    else if (k % 256 == 1)
      pa = d;
    else if (k % 256 == 3)
      pb = d;
    else if (k % 256 == 4)
      bk = d & CBS_BANK_MASK;
  endtask
  task automatic rdm(input logic [7:0] a);
    int k;
    k = key(a);
    k = (k % 256 >= 64) ? mdl[k] : (k % 256 == 1) ? pa : (k % 256 == 3) ? pb
      : (k % 256 == 4) ? bk : 0;
    rd(a, 8'(k));
  endtask
  task automatic report_and_stop;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #(25ns * 5000);
    miscompares++;
    report_and_stop();
  end
  initial begin
    logic [8:0] s;
    logic [7:0] a, b;
    logic       c;
    cbs_alu_op_t op;
    {reset_i, touch_enable_i, sfr_req_i, alu_i, evt_i, pc_i, fl} = '0;
    reset_i = 1'b1;
    touch_enable_i = 1'b1;
    void'($urandom(32'h4204e8d2));
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (rv[i]) rd(rv[i][15:8], rv[i][7:0]);
    chk(clk_cfg_o.lcd_div, CBS_LCD_DIV3);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      v[4:3] = i[1:0];
      wr(CBS_ADDR_CTRL_A, v);
      rd(CBS_ADDR_CTRL_A, v);
      chk(clk_cfg_o.lcd_div, v[4] ? CBS_LCD_DIV8 : v[3] ? CBS_LCD_DIV4 : CBS_LCD_DIV3);
      chk({clk_cfg_o.timer2_src, clk_cfg_o.low_freq_src, clk_cfg_o.sub_clock_keep,
           clk_cfg_o.sub_clock_src, clk_cfg_o.crystal_low_power}, {v[7:5], v[2:0]});
      v[7:6] = i[1:0];
      wr(CBS_ADDR_CTRL_B, v);
      rd(CBS_ADDR_CTRL_B, v & CBS_CB_MASK);
      chk({clk_cfg_o.irq_rise_en, clk_cfg_o.irq_fall_en, clk_cfg_o.buzzer_src,
           clk_cfg_o.crystal_keep}, {v[7:6], v[1:0]});
    end
    @(posedge clk_i) touch_enable_i <= 1'b0;
    wr(CBS_ADDR_CTRL_A, 8'hFF);
    rd(CBS_ADDR_CTRL_A, 8'h3F);
    @(posedge clk_i) touch_enable_i <= 1'b1;
    $display("test control registers done");
    for (int i = 0; i < 4; i++) begin
      wrm(CBS_ADDR_BANK, 8'(8'h20 + i));
      #1 chk({prog_bank_o, data_bank_o}, {1'b1, i[1:0]});
      wrm(CBS_ADDR_PTR_B, 8'(8'h60 + i));
      wrm(CBS_ADDR_PORT_B, 8'($urandom));
      wrm(CBS_ADDR_PTR_A, 8'(8'h60 + i));
      wrm(CBS_ADDR_PORT_A, 8'($urandom));
      wrm(8'(8'h70 + i), 8'($urandom));
    end
    for (int i = 0; i < 4; i++) begin
      wrm(CBS_ADDR_BANK, 8'(i));
      wrm(CBS_ADDR_PTR_B, 8'(8'h60 + i));
      rdm(CBS_ADDR_PORT_B);
      rdm(8'(8'h60 + i));
      rdm(8'(8'h70 + i));
      wrm(CBS_ADDR_PTR_B, CBS_ADDR_BANK);
      rdm(CBS_ADDR_PORT_B);
      wrm(CBS_ADDR_PTR_B, CBS_ADDR_PORT_B);
      rdm(CBS_ADDR_PORT_B);
    end
    $display("test banks and pointers done");
    repeat (4) begin
      @(posedge clk_i) pc_i <= 14'($urandom);
      v = 8'($urandom);
      wr(CBS_ADDR_PC_LOW, v);
      #1 chk({pc_load_o, dummy_cycle_o, pc_target_o}, {2'b11, pc_i[13:8], v});
    end
    $display("test program counter done");
    for (int i = 0; i < 40; i++) begin
      op = cbs_alu_op_t'(1 + $urandom % 5);
      a = (i % 8 == 0) ? 8'h00 : 8'($urandom);
      b = (i % 8 == 0) ? 8'h00 : 8'($urandom);
      c = (i % 8 == 0) ? 1'b0 : 1'($urandom);
      @(posedge clk_i) alu_i <= '{op, a, b, c};
      @(posedge clk_i) alu_i <= '0;
      if (op == CBS_OP_SUB)
        b = ~b;
      s = {1'b0, a} + {1'b0, b} + 9'(c);
      if (op == CBS_OP_ADD || op == CBS_OP_SUB)
        fl[3:0] = {a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00,
                   (5'(a[3:0]) + 5'(b[3:0]) + 5'(c)) > 5'h0F, s[8]};
      else if (op == CBS_OP_LOGIC)
        fl[2] = (a == 8'h00);
      else
        fl[0] = (op == CBS_OP_RLC) ? a[7] : a[0];
      #1 chk(flags_o, fl);
    end
    $display("test arithmetic flags done");
    foreach (ev[i]) begin
      evt(ev[i]);
      fl[5] = ev[i][4] || (fl[5] && !ev[i][3] && !ev[i][2]);
      fl[4] = ev[i][2] || (fl[4] && !ev[i][3]);
      chk(flags_o, fl);
    end
    wr(CBS_ADDR_FLAGS, 8'hFF);
    fl[3:0] = 4'hF;
    rd(CBS_ADDR_FLAGS, fl);
    $display("test system flags done");
    wrm(CBS_ADDR_BANK, 8'h23);
    evt(5'h03);
    chk({prog_bank_o, data_bank_o}, 3'h7);
    evt(5'h02);
    bk = 0;
    chk({prog_bank_o, data_bank_o}, 3'h0);
    rdm(CBS_ADDR_BANK);
    $display("test warm reset done");
    report_and_stop();
  end
endmodule
